// ===== logic/pfr_cfg.svh
// constants for the pfc fault response block
`ifndef PFR_CFG_SVH
`define PFR_CFG_SVH
// register command codes
`define PFR_ADDR_OCP 16'hFE00
`define PFR_ADDR_OVP 16'hFE01
`define PFR_ADDR_OLP 16'hFE02
`define PFR_ADDR_SUP 16'hFE03
`define PFR_CMD_MAKER 16'hF1
// writable bit masks; reserved bits read zero
`define PFR_MASK_OCP 8'hF0
`define PFR_MASK_RESP 8'hC0
`define PFR_MASK_SUP 8'h7F
`define PFR_RST_VAL 8'h00
// field positions
`define PFR_RESP_HI 7
`define PFR_RESP_LO 6
`define PFR_NCYC_HI 5
`define PFR_NCYC_LO 4
`define PFR_SUP_SAVE 6
`define PFR_SUP_WAIT_HI 5
`define PFR_SUP_WAIT_LO 3
`define PFR_SUP_RELOAD 2
`define PFR_SUP_DEB 1
`define PFR_SUP_IGNORE 0
// timing
`define PFR_CLK_MHZ 40
`define PFR_DEB_FAST_NS 2560
`define PFR_DEB_SLOW_US 660
`define PFR_RETRY_MS 588
`define PFR_DEB_FAST_CYC ((`PFR_DEB_FAST_NS * `PFR_CLK_MHZ + 999) / 1000)
`define PFR_DEB_SLOW_CYC (`PFR_DEB_SLOW_US * `PFR_CLK_MHZ)
`define PFR_RETRY_CYC (`PFR_RETRY_MS * 1000 * `PFR_CLK_MHZ)
// manufacturer data area in eeprom
`define PFR_MAKER_BASE 16'h0000
`define PFR_MAKER_LEN 8'h08
`endif

// ===== logic/pfr_pkg.sv
// types for the pfc fault response block
package pfr_pkg;
  typedef enum logic [4:0] {
    PFR_RUN = 5'b00001,
    PFR_COUNT = 5'b00010,
    PFR_RETRY = 5'b00100,
    PFR_WAIT_PON = 5'b01000,
    PFR_LATCHED = 5'b10000
  } pfr_state_t;
  typedef enum logic [1:0] {
    PFR_ACT_IGNORE = 2'h0,
    PFR_ACT_RESTART = 2'h1,
    PFR_ACT_WAIT_PON = 2'h2,
    PFR_ACT_LATCH = 2'h3
  } pfr_act_t;
  // fault flag identifiers; flag vector bit index plus one, zero for none
  typedef enum logic [2:0] {
    PFR_ID_NONE = 3'h0,
    PFR_ID_OCP = 3'h1,
    PFR_ID_OVP = 3'h2,
    PFR_ID_OLP = 3'h3,
    PFR_ID_SUP = 3'h4
  } pfr_id_t;
endpackage

// ===== logic/pfr_debounce.sv
// selectable-time debounce filter for the supply overvoltage input
`timescale 1ns/1ps
`include "pfr_cfg.svh"
module pfr_debounce #(
  parameter int SLOW_CYC = `PFR_DEB_SLOW_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // control
  input wire logic i_fast_sel,
  input wire logic i_raw,
  // filtered level
  output logic o_level
);
  localparam int FAST_CYC = `PFR_DEB_FAST_CYC;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic level_q;
  logic [31:0] limit;
  logic differs;

  assign limit = i_fast_sel ? 32'(FAST_CYC) : 32'(SLOW_CYC); // RL11
  assign differs = i_raw != level_q;
  // the level only follows the input after it has stood still for the whole time
  assign cnt_d = !differs ? 32'h0 : cnt_q + 32'h1;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cnt_q <= 32'h0;
      level_q <= 1'b0;
    end else if (differs && cnt_d >= limit) begin
      cnt_q <= 32'h0;
      level_q <= i_raw;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign o_level = level_q;
endmodule

// ===== logic/pfr_fault_ctrl.sv
// fault response control: register file, fault state machine, maker data read
//
// Behaviour
// RL1: overcurrent ignore still cuts each pulse short
// RL2: mode 01: allow cycles, shut, soft start
// RL3: mode 10: cut pulses, shut, await power-on
// RL4: mode 11: disable PWM until flag cleared
// RL5: cycle field gives one, two, four, eight
// RL6: overvoltage field: ignore, restart, await, latch
// RL7: open-loop field: ignore, restart, await, latch
// RL8: bit 6 saves first flag at shutdown
// RL9: retry wait is field times 588 ms (code loads the field for supply overvoltage only; other faults retry at once)
// RL10: bit 2 reloads EEPROM on fault response
// RL11: bit 1 selects 2.56 us or 660 us
// RL12: bit 0 ignores supply overvoltage faults
// RL13: command F1 returns eeprom maker data
// RL14: cycle counter restarts; reserved bits read zero
`timescale 1ns/1ps
`include "pfr_cfg.svh"
module pfr_fault_ctrl #(
  parameter int RETRY_CYC = `PFR_RETRY_CYC,
  parameter int DEB_SLOW_CYC = `PFR_DEB_SLOW_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // decoded pmbus register access
  input wire logic [15:0] i_cmd_code,
  input wire logic i_wr_en,
  input wire logic [7:0] i_wr_data,
  input wire logic i_rd_en,
  output logic [7:0] o_rd_data,
  // maker data block read answer
  output logic o_blk_valid,
  output logic [7:0] o_blk_data,
  output logic o_blk_last,
  // eeprom port
  output logic o_ee_rd_req,
  output logic [15:0] o_ee_rd_addr,
  input wire logic i_ee_rd_valid,
  input wire logic [7:0] i_ee_rd_data,
  output logic o_ee_save_req,
  output logic [2:0] o_ee_save_id,
  output logic o_ee_reload_req,
  // fault detectors and power stage
  input wire logic i_ocp_fast,
  input wire logic i_ovp_fast,
  input wire logic i_olp,
  input wire logic i_sup_ov_raw,
  input wire logic i_sw_cycle,
  input wire logic i_power_on_request,
  input wire logic [3:0] i_flag_clear,
  output logic o_pwm_en,
  output logic o_pulse_term,
  output logic o_soft_start,
  output logic [3:0] o_fault_flags
);
  import pfr_pkg::*;

  // cycles allowed after an overcurrent detection
  function automatic logic [3:0] ncyc(input logic [1:0] code);
    ncyc = 4'h1 << code; // RL5
  endfunction

  function automatic pfr_act_t act_of(input logic [7:0] r);
    act_of = pfr_act_t'(r[`PFR_RESP_HI:`PFR_RESP_LO]);
  endfunction

  logic [7:0] ocp_q;
  logic [7:0] ovp_q;
  logic [7:0] olp_q;
  logic [7:0] sup_q;
  logic [7:0] rd_q;
  pfr_state_t state_q;
  pfr_state_t state_d;
  logic [3:0] cyc_q;
  logic [31:0] unit_q;
  logic [2:0] steps_q;
  logic [3:0] flags_q;
  logic [2:0] first_q;
  logic term_q;
  logic ss_q;
  logic save_q;
  logic reload_q;
  logic blk_busy_q;
  logic blk_wait_q;
  logic [7:0] blk_idx_q;
  logic blk_valid_q;
  logic [7:0] blk_data_q;
  logic blk_last_q;
  logic sup_level;
  logic sup_prev_q;

  // register decode
  wire hit_ocp = i_cmd_code == `PFR_ADDR_OCP;
  wire hit_ovp = i_cmd_code == `PFR_ADDR_OVP;
  wire hit_olp = i_cmd_code == `PFR_ADDR_OLP;
  wire hit_sup = i_cmd_code == `PFR_ADDR_SUP;
  wire hit_maker = i_cmd_code == `PFR_CMD_MAKER;
  logic [7:0] rd_mux;
  always_comb begin
    if (hit_ocp) begin
      rd_mux = ocp_q;
    end else if (hit_ovp) begin
      rd_mux = ovp_q;
    end else if (hit_olp) begin
      rd_mux = olp_q;
    end else if (hit_sup) begin
      rd_mux = sup_q;
    end else begin
      rd_mux = 8'h00;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ocp_q <= `PFR_RST_VAL;
      ovp_q <= `PFR_RST_VAL;
      olp_q <= `PFR_RST_VAL;
      sup_q <= `PFR_RST_VAL;
      rd_q <= 8'h00;
    end else begin
      // write masks keep reserved bits at zero so reads return zero there
      if (i_wr_en && hit_ocp) ocp_q <= i_wr_data & `PFR_MASK_OCP; // RL14
      if (i_wr_en && hit_ovp) ovp_q <= i_wr_data & `PFR_MASK_RESP;
      if (i_wr_en && hit_olp) olp_q <= i_wr_data & `PFR_MASK_RESP;
      if (i_wr_en && hit_sup) sup_q <= i_wr_data & `PFR_MASK_SUP;
      if (i_rd_en) rd_q <= rd_mux;
    end
  end
  assign o_rd_data = rd_q;

  // supply overvoltage filter
  pfr_debounce #(
    .SLOW_CYC(DEB_SLOW_CYC)
  ) u_deb (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_fast_sel(sup_q[`PFR_SUP_DEB]),
    .i_raw(i_sup_ov_raw),
    .o_level(sup_level)
  );

  // fault events
  pfr_act_t ocp_act;
  pfr_act_t ovp_act;
  pfr_act_t olp_act;
  assign ocp_act = act_of(ocp_q);
  assign ovp_act = act_of(ovp_q);
  assign olp_act = act_of(olp_q);
  wire sup_ev = sup_level && !sup_prev_q && !sup_q[`PFR_SUP_IGNORE]; // RL12
  // the pwm still switches while counting, so other faults act there as well
  wire running = state_q == PFR_RUN || state_q == PFR_COUNT;
  wire ocp_go = running && i_ocp_fast && ocp_act != PFR_ACT_IGNORE;
  wire ovp_go = running && i_ovp_fast && ovp_act != PFR_ACT_IGNORE; // RL6
  wire olp_go = running && i_olp && olp_act != PFR_ACT_IGNORE; // RL7
  wire [3:0] set_ev = {sup_ev, i_olp, i_ovp_fast, i_ocp_fast};
  wire cyc_done = state_q == PFR_COUNT && i_sw_cycle
    && (cyc_q + 4'h1) >= ncyc(ocp_q[`PFR_NCYC_HI:`PFR_NCYC_LO]); // RL5
  wire retry_done = steps_q == 3'h0;

  // action chosen on a shutdown decision
  pfr_act_t shut_act;
  always_comb begin
    if (sup_ev) begin
      shut_act = PFR_ACT_RESTART;
    end else if (cyc_done) begin
      shut_act = ocp_act;
    end else if (ovp_go) begin
      shut_act = ovp_act;
    end else begin
      shut_act = olp_act;
    end
  end
  wire shut_now = sup_ev || cyc_done || ovp_go || olp_go;

  always_comb begin
    state_d = state_q;
    case (state_q)
      PFR_RUN: begin
        if (shut_now) begin
          case (shut_act)
            PFR_ACT_WAIT_PON: state_d = PFR_WAIT_PON;
            PFR_ACT_LATCH: state_d = PFR_LATCHED;
            default: state_d = PFR_RETRY;
          endcase
        end else if (ocp_go) begin
          state_d = PFR_COUNT;
        end
      end
      PFR_COUNT: begin
        if (shut_now) begin
          case (shut_act)
            PFR_ACT_WAIT_PON: state_d = PFR_WAIT_PON; // RL3
            PFR_ACT_LATCH: state_d = PFR_LATCHED; // RL4
            default: state_d = PFR_RETRY; // RL2
          endcase
        end
      end
      PFR_RETRY: begin
        if (retry_done) state_d = PFR_RUN;
      end
      PFR_WAIT_PON: begin
        if (i_power_on_request) state_d = PFR_RUN;
      end
      PFR_LATCHED: begin
        // all flags clear (including this clear cycle) releases the latch
        if ((flags_q & ~i_flag_clear) == 4'h0 && set_ev == 4'h0) state_d = PFR_RUN;
      end
      default: state_d = PFR_RUN;
    endcase
  end

  wire entering_off = state_d != PFR_RUN && state_d != PFR_COUNT
    && (state_q == PFR_RUN || state_q == PFR_COUNT);
  wire leaving_off = state_d == PFR_RUN && state_q != PFR_RUN && state_q != PFR_COUNT;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q <= PFR_RUN;
      cyc_q <= 4'h0;
      unit_q <= 32'h0;
      steps_q <= 3'h0;
      flags_q <= 4'h0;
      first_q <= 3'h0;
      term_q <= 1'b0;
      ss_q <= 1'b0;
      save_q <= 1'b0;
      reload_q <= 1'b0;
      sup_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sup_prev_q <= sup_level;
      // a new detection starts the tolerance count from zero
      if (state_q != PFR_COUNT) cyc_q <= 4'h0; // RL14
      else if (i_sw_cycle) cyc_q <= cyc_q + 4'h1;
      // the overcurrent pulse is always cut, and each pulse while counting in mode 10
      term_q <= i_ocp_fast // RL1
        || (state_q == PFR_COUNT && ocp_act == PFR_ACT_WAIT_PON && i_sw_cycle); // RL3
      // retry wait counts down in 588 ms units after a supply fault; a zero field or any other fault restarts at once
      if (entering_off) begin
        steps_q <= sup_ev ? sup_q[`PFR_SUP_WAIT_HI:`PFR_SUP_WAIT_LO] : 3'h0; // RL9
        unit_q <= 32'h0;
      end else if (state_q == PFR_RETRY && !retry_done) begin
        if (unit_q >= 32'(RETRY_CYC - 1)) begin
          unit_q <= 32'h0;
          steps_q <= steps_q - 3'h1; // RL9
        end else begin
          unit_q <= unit_q + 32'h1;
        end
      end
      // set wins over a clear arriving in the same cycle
      flags_q <= (flags_q & ~i_flag_clear) | set_ev;
      if ((flags_q & ~i_flag_clear) == 4'h0) begin
        if (set_ev[0]) first_q <= PFR_ID_OCP;
        else if (set_ev[1]) first_q <= PFR_ID_OVP;
        else if (set_ev[2]) first_q <= PFR_ID_OLP;
        else if (set_ev[3]) first_q <= PFR_ID_SUP;
        else first_q <= PFR_ID_NONE;
      end
      save_q <= entering_off && sup_q[`PFR_SUP_SAVE]; // RL8
      reload_q <= entering_off && sup_q[`PFR_SUP_RELOAD]; // RL10
      // every way back to running goes through soft start
      ss_q <= leaving_off; // RL2
    end
  end

  assign o_pwm_en = state_q == PFR_RUN || state_q == PFR_COUNT; // RL4
  assign o_pulse_term = term_q;
  assign o_soft_start = ss_q;
  assign o_fault_flags = flags_q;
  assign o_ee_save_req = save_q;
  assign o_ee_save_id = first_q;
  assign o_ee_reload_req = reload_q;

  // maker data block read, one eeprom byte at a time
  wire blk_start = i_rd_en && hit_maker && !blk_busy_q;
  assign o_ee_rd_req = blk_busy_q && !blk_wait_q;
  assign o_ee_rd_addr = `PFR_MAKER_BASE + {8'h00, blk_idx_q};
  wire blk_end = (blk_idx_q + 8'h01) == `PFR_MAKER_LEN;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      blk_busy_q <= 1'b0;
      blk_wait_q <= 1'b0;
      blk_idx_q <= 8'h00;
      blk_valid_q <= 1'b0;
      blk_data_q <= 8'h00;
      blk_last_q <= 1'b0;
    end else begin
      blk_valid_q <= 1'b0;
      blk_last_q <= 1'b0;
      if (blk_start) begin
        blk_busy_q <= 1'b1; // RL13
        blk_wait_q <= 1'b0;
        blk_idx_q <= 8'h00;
      end else if (o_ee_rd_req) begin
        blk_wait_q <= 1'b1;
      end else if (blk_busy_q && i_ee_rd_valid) begin
        blk_valid_q <= 1'b1; // RL13
        blk_data_q <= i_ee_rd_data;
        blk_last_q <= blk_end;
        blk_wait_q <= 1'b0;
        blk_idx_q <= blk_idx_q + 8'h01;
        if (blk_end) blk_busy_q <= 1'b0;
      end
    end
  end
  assign o_blk_valid = blk_valid_q;
  assign o_blk_data = blk_data_q;
  assign o_blk_last = blk_last_q;
endmodule

// ===== verif/pfr_fault_ctrl_assertions.sv
// assertion checker bound to the fault response block
`timescale 1ns/1ps
module pfr_chk (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // watched ports
  input wire logic [15:0] i_cmd_code,
  input wire logic i_rd_en,
  input wire logic [7:0] o_rd_data,
  input wire logic o_blk_valid,
  input wire logic [7:0] o_blk_data,
  input wire logic o_blk_last,
  input wire logic o_ee_rd_req,
  input wire logic [15:0] o_ee_rd_addr,
  input wire logic i_ee_rd_valid,
  input wire logic [7:0] i_ee_rd_data,
  input wire logic o_ee_save_req,
  input wire logic [2:0] o_ee_save_id,
  input wire logic i_ocp_fast,
  input wire logic [3:0] i_flag_clear,
  input wire logic o_pwm_en,
  input wire logic o_pulse_term,
  input wire logic o_soft_start,
  input wire logic [3:0] o_fault_flags
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  term_on_ocp_a: assert property (i_ocp_fast && o_pwm_en |=> o_pulse_term)
    else $error("pulse not cut after overcurrent");
  rsvd_ocp_a: assert property (i_rd_en && i_cmd_code == 16'hFE00 |=> o_rd_data[3:0] == 4'h0)
    else $error("reserved overcurrent bits not zero");
  rsvd_sup_a: assert property (i_rd_en && i_cmd_code == 16'hFE03 |=> !o_rd_data[7])
    else $error("reserved supply bit not zero");
  unmapped_rd_a: assert property (i_rd_en && !(i_cmd_code inside {16'hFE00, 16'hFE01,
    16'hFE02, 16'hFE03, 16'h00F1}) |=> o_rd_data == 8'h00)
    else $error("unmapped read not zero");
  ee_addr_a: assert property (o_ee_rd_req |-> o_ee_rd_addr < 16'h0008)
    else $error("maker address out of area");
  blk_byte_a: assert property (i_ee_rd_valid |=> o_blk_valid && o_blk_data == $past(i_ee_rd_data))
    else $error("maker byte not passed on");
  blk_last_a: assert property (o_blk_last |-> o_blk_valid)
    else $error("last flag without byte");
  soft_after_a: assert property ($rose(o_pwm_en) |-> o_soft_start)
    else $error("no soft start after restart");
  save_id_a: assert property (o_ee_save_req |-> o_ee_save_id inside {3'h1, 3'h2, 3'h3, 3'h4})
    else $error("saved flag id invalid");
  flag_hold_a: assert property ($fell(o_fault_flags[0]) |-> $past(i_flag_clear[0]))
    else $error("overcurrent flag dropped without clear");
  cover property (o_blk_last);
  cover property (o_ee_save_req);
  cover property ($fell(o_pwm_en));
endmodule
bind pfr_fault_ctrl pfr_chk pfr_chk_i (.i_clk, .i_reset, .i_cmd_code, .i_rd_en, .o_rd_data,
  .o_blk_valid, .o_blk_data, .o_blk_last, .o_ee_rd_req, .o_ee_rd_addr, .i_ee_rd_valid,
  .i_ee_rd_data, .o_ee_save_req, .o_ee_save_id, .i_ocp_fast, .i_flag_clear, .o_pwm_en,
  .o_pulse_term, .o_soft_start, .o_fault_flags);

// ===== verif/pfr_ee_model.sv
// behavioural eeprom answering maker data reads
`timescale 1ns/1ps
module pfr_ee_model (
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic [15:0] i_addr,
  input wire logic i_slow,
  output logic o_valid,
  output logic [7:0] o_data
);
  logic [15:0] addr_q = 16'h0000;
  logic [2:0] wait_q = 3'h0;
  initial o_valid = 1'b0;
  initial o_data = 8'h00;
  // one byte per request, after one or four cycles
  always @(posedge i_clk) begin
    if (i_req) begin
      addr_q <= i_addr;
      wait_q <= i_slow ? 3'h4 : 3'h1;
    end else if (wait_q != 3'h0) begin
      wait_q <= wait_q - 3'h1;
    end
    o_valid <= (wait_q == 3'h1) && !i_req;
    // data line is not held between bytes
    o_data <= (wait_q == 3'h1) ? (8'hA0 ^ addr_q[7:0]) : ~o_data;
  end
endmodule

// ===== verif/pfr_fault_ctrl_tb.sv
// self-checking bench for the fault response block
`timescale 1ns/1ps
module pfr_fault_ctrl_tb;
  logic i_clk = 1'b0, i_reset = 1'b1, i_wr_en = 1'b0, i_rd_en = 1'b0, slow = 1'b0;
  logic i_ocp_fast = 1'b0, i_ovp_fast = 1'b0, i_olp = 1'b0, i_sup_ov_raw = 1'b0;
  logic i_sw_cycle = 1'b0, i_power_on_request = 1'b0, rd_p = 1'b0;
  logic [15:0] i_cmd_code = 16'h0000, code, o_ee_rd_addr;
  logic [7:0] i_wr_data = 8'h00, lf = 8'h1D, i_ee_rd_data, o_rd_data, o_blk_data;
  logic [3:0] i_flag_clear = 4'h0, o_fault_flags;
  logic i_ee_rd_valid, o_blk_valid, o_blk_last, o_ee_rd_req, o_ee_save_req, o_ee_reload_req;
  logic o_pwm_en, o_pulse_term, o_soft_start;
  logic [2:0] o_ee_save_id;
  logic [7:0] mk[5] = '{8'hF0, 8'hC0, 8'hC0, 8'h7F, 8'h00};
  logic [8:0] qb[$];
  logic [7:0] qr[$];
  logic [2:0] qs[$];
  int n_fail = 0, compares = 0, n_rl = 0, cnt;
  always #12.5 i_clk = ~i_clk;
  pfr_fault_ctrl #(.RETRY_CYC(20), .DEB_SLOW_CYC(10)) pfr_fault_ctrl_i (.i_clk, .i_reset,
    .i_cmd_code, .i_wr_en, .i_wr_data, .i_rd_en, .o_rd_data, .o_blk_valid, .o_blk_data,
    .o_blk_last, .o_ee_rd_req, .o_ee_rd_addr, .i_ee_rd_valid, .i_ee_rd_data, .o_ee_save_req,
    .o_ee_save_id, .o_ee_reload_req, .i_ocp_fast, .i_ovp_fast, .i_olp, .i_sup_ov_raw,
    .i_sw_cycle, .i_power_on_request, .i_flag_clear, .o_pwm_en, .o_pulse_term,
    .o_soft_start, .o_fault_flags);
  pfr_ee_model pfr_ee_model_i (.i_clk, .i_req(o_ee_rd_req), .i_addr(o_ee_rd_addr),
    .i_slow(slow), .o_valid(i_ee_rd_valid), .o_data(i_ee_rd_data));
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge i_clk);
    #2;
  endtask
  // an idle cycle follows each access so strobes never toggle in one step
  task automatic bus(input logic [15:0] c, input logic wr, input logic [7:0] d);
    i_cmd_code = c;
    i_wr_en = wr;
    i_rd_en = !wr;
    i_wr_data = d;
    tk(1);
    i_wr_en = 1'b0;
    i_rd_en = 1'b0;
    tk(1);
  endtask
  task automatic wt(input logic ss, input logic lvl);
    cnt = 0;
    while ((ss ? o_soft_start : o_pwm_en) !== lvl) begin
      tk(1);
      cnt++;
      if (cnt > 300) begin
        n_fail++;
        print_verdict();
      end
    end
  endtask
  task automatic clr;
    i_flag_clear = 4'hF;
    tk(1);
    i_flag_clear = 4'h0;
  endtask
  task automatic fin(input int m);
    if (m >= 2) begin
      tk(3);
      chk(9'(o_pwm_en), 9'h0);
    end
    i_power_on_request = (m == 2);
    if (m == 3) clr();
    if (m != 0) wt(1'b1, 1'b1);
    i_power_on_request = 1'b0;
    clr();
    chk(9'(o_pwm_en), 9'h1);
  endtask
  function automatic logic [7:0] nx(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  always @(posedge i_clk) begin
    if (rd_p) chk({1'b0, o_rd_data}, {1'b0, qr.pop_front()});
    if (o_blk_valid) chk({o_blk_last, o_blk_data}, qb.pop_front());
    if (o_ee_save_req) chk({6'h0, o_ee_save_id}, {6'h0, qs.pop_front()});
    if (o_ee_reload_req) n_rl++;
    rd_p <= i_rd_en && i_cmd_code != 16'h00F1;
  end
  initial begin
    tk(3);
    i_reset = 1'b0;
    for (int k = 0; k < 5; k++) begin
      code = (k == 4) ? 16'hFE07 : 16'hFE00 + 16'(k);
      lf = nx(lf);
      qr.push_back(8'h00);
      bus(code, 1'b0, 8'h00);
      bus(code, 1'b1, lf);
      qr.push_back(lf & mk[k]);
      bus(code, 1'b0, 8'h00);
      bus(code, 1'b1, 8'h00);
    end
    $display("registers done");
    // s: 0 overvoltage, 1 open loop, 2 overcurrent; j 4 is latch with one cycle
    for (int s = 0; s < 3; s++) begin
      for (int j = 0; j < 5; j++) begin
        code = (s == 2) ? 16'hFE00 : 16'hFE01 + 16'(s);
        bus(code, 1'b1, {(j == 4) ? 2'h3 : 2'(j), 2'(j), 4'h0});
        i_ovp_fast = (s == 0);
        i_olp = (s == 1);
        i_ocp_fast = (s == 2);
        tk(1);
        {i_ovp_fast, i_olp, i_ocp_fast} = 3'h0;
        chk(9'(o_fault_flags), 9'(4'h1 << ((s + 1) % 3)));
        if (s == 2) chk(9'(o_pulse_term), 9'h1);
        else chk(9'(o_pwm_en), 9'(j == 0));
        for (int k = 0; s == 2 && j != 0 && k < (1 << (j & 3)); k++) begin
          tk(1);
          i_sw_cycle = 1'b1;
          tk(1);
          i_sw_cycle = 1'b0;
          chk(9'(o_pulse_term), 9'(j == 2));
          chk(9'(o_pwm_en), 9'(k != (1 << (j & 3)) - 1));
        end
        fin((j == 4) ? 3 : j);
      end
    end
    $display("fault modes done");
    qs.push_back(3'h4);
    bus(16'hFE03, 1'b1, 8'h54);
    i_sup_ov_raw = 1'b1;
    wt(1'b0, 1'b0);
    chk(9'(cnt >= 10 && cnt <= 13), 9'h1);
    i_sup_ov_raw = 1'b0;
    wt(1'b0, 1'b1);
    chk(9'(cnt >= 40 && cnt <= 43), 9'h1);
    clr();
    bus(16'hFE03, 1'b1, 8'h02);
    i_sup_ov_raw = 1'b1;
    wt(1'b0, 1'b0);
    chk(9'(cnt >= 103 && cnt <= 106), 9'h1);
    i_sup_ov_raw = 1'b0;
    wt(1'b0, 1'b1);
    clr();
    bus(16'hFE03, 1'b1, 8'h01);
    // the filtered level must fall first, or no new rise could be ignored
    tk(110);
    i_sup_ov_raw = 1'b1;
    tk(150);
    chk(9'(o_pwm_en), 9'h1);
    chk(9'(o_fault_flags), 9'h0);
    i_sup_ov_raw = 1'b0;
    chk(9'(n_rl), 9'h1);
    $display("supply done");
    for (int r = 0; r < 2; r++) begin
      slow = r[0];
      for (int b = 0; b < 8; b++) qb.push_back({b == 7, 8'hA0 ^ 8'(b)});
      bus(16'h00F1, 1'b0, 8'h00);
      bus(16'h00F1, 1'b0, 8'h00);
      for (cnt = 0; qb.size() != 0 && cnt < 100; cnt++) tk(1);
      chk(9'(qb.size()), 9'h0);
      if (cnt >= 100) print_verdict();
    end
    tk(10);
    $display("maker read done");
    print_verdict();
  end
endmodule
